// [cgm_clock_gen.sv]
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module cgm_clock_gen #(
    parameter int LOCK_CYC = cgm_pkg::CGM_LOCK_CYC,
    parameter int LOSS_CYC = cgm_pkg::CGM_OSC_LOSS_CYC
) (
    input  wire logic              I_CORE_CLK,
    input  wire logic              I_NRST,
    input  wire logic [7:0]        I_AWADDR,
    input  wire logic              I_AWVALID,
    output logic                   O_AWREADY,
    input  wire logic [31:0]       I_WDATA,
    input  wire logic [3:0]        I_WSTRB,
    input  wire logic              I_WVALID,
    output logic                   O_WREADY,
    output logic [1:0]             O_BRESP,
    output logic                   O_BVALID,
    input  wire logic              I_BREADY,
    input  wire logic [7:0]        I_ARADDR,
    input  wire logic              I_ARVALID,
    output logic                   O_ARREADY,
    output logic [31:0]            O_RDATA,
    output logic [1:0]             O_RRESP,
    output logic                   O_RVALID,
    input  wire logic              I_RREADY,
    input  wire logic              I_OSC_CLK,
    input  wire cgm_pkg::cgm_ps_type I_PS_STATE,
    input  wire logic              I_STAB_COUNTING,
    output cgm_pkg::cgm_gate_type  O_GATE,
    output logic                   O_FXX_TICK,
    output logic                   O_WDT_TICK,
    output logic                   O_MON_ACTIVE,
    output logic                   O_OSC_FAIL_N,
    output logic                   O_TIMER_HIZ
);

    // ======================================================
    // State
    typedef struct packed {
        logic                  aw_got;
        logic [7:0]            awaddr;
        logic                  w_got;
        logic [7:0]            wdata;
        logic                  wstrb0;
        logic                  awready;
        logic                  wready;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  arready;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
        logic                  osc_watch_enable;
        logic                  pll_mode;
        logic                  armed;
        cgm_pkg::cgm_seq_type  seq;
        logic [31:0]           lock_cnt;
        logic                  s1;
        logic                  s2;
        logic                  s3;
        logic [15:0]           loss_cnt;
        logic                  mon_active;
        logic                  fail;
        logic                  osc_ok;
        logic [15:0]           per_cnt;
        logic [15:0]           period;
        logic [15:0]           phase;
        logic [2:0]            ticks_left;
        logic                  fxx_tick;
        logic [9:0]            wdt_cnt;
        logic                  wdt_tick;
        cgm_pkg::cgm_gate_type gate;
    } cgm_state_type;

    cgm_state_type st_reg;
    cgm_state_type st_next;

    // Address decode shared by both read and write paths
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == cgm_pkg::CGM_OFS_MODE) || (a == cgm_pkg::CGM_OFS_BITSET)
               || (a == cgm_pkg::CGM_OFS_BITCLR) || (a == cgm_pkg::CGM_OFS_PROTECT)
               || (a == cgm_pkg::CGM_OFS_CTRL) || (a == cgm_pkg::CGM_OFS_STATUS);
    endfunction

    logic rise;
    logic pll_on;
    logic [15:0] step;
    logic [7:0] mode_byte;

    // ======================================================
    // Next state
    always_comb begin
        st_next = st_reg;
        rise = st_reg.s2 & ~st_reg.s3;
        pll_on = st_reg.gate.pll;
        step = st_reg.period >> 3;
        mode_byte = {7'h00, st_reg.osc_watch_enable};
        st_next.fxx_tick = 1'b0;
        st_next.wdt_tick = 1'b0;

        // Oscillator pin synchroniser
        st_next.s1 = I_OSC_CLK;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;

        // Write channels
        if (I_AWVALID && st_reg.awready) begin
            st_next.aw_got = 1'b1;
            st_next.awaddr = I_AWADDR;
        end
        if (I_WVALID && st_reg.wready) begin
            st_next.w_got = 1'b1;
            st_next.wdata = I_WDATA[7:0];
            st_next.wstrb0 = I_WSTRB[0];
        end
        if (st_reg.bvalid && I_BREADY) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = addr_ok(st_reg.awaddr) ? cgm_pkg::CGM_RESP_OKAY : cgm_pkg::CGM_RESP_SLVERR;
            // Any write consumes the unlock; only the key re-arms it
            st_next.armed = 1'b0;
            case (st_reg.awaddr)
                cgm_pkg::CGM_OFS_MODE: begin
                    // Ones are ORed in so a zero can never clear the enable
                    if (st_reg.armed && st_reg.wstrb0) begin
                        st_next.osc_watch_enable = st_reg.osc_watch_enable
                                                 | st_reg.wdata[cgm_pkg::CGM_EN_BIT];
                    end
                end
                cgm_pkg::CGM_OFS_BITSET: begin
                    // Bit operation: low three data bits give the bit number
                    if (st_reg.armed && st_reg.wstrb0 && st_reg.wdata[2:0] == 3'h0) begin
                        st_next.osc_watch_enable = 1'b1;
                    end
                end
                cgm_pkg::CGM_OFS_BITCLR: begin
                    st_next.osc_watch_enable = st_reg.osc_watch_enable;
                end
                cgm_pkg::CGM_OFS_PROTECT: begin
                    st_next.armed = st_reg.wstrb0 && (st_reg.wdata == cgm_pkg::CGM_UNLOCK_KEY);
                end
                cgm_pkg::CGM_OFS_CTRL: begin
                    if (st_reg.wstrb0) begin
                        st_next.pll_mode = st_reg.wdata[cgm_pkg::CGM_PLL_BIT];
                    end
                end
                default: begin
                    st_next.armed = 1'b0;
                end
            endcase
        end
        st_next.awready = ~st_next.aw_got & ~st_next.bvalid;
        st_next.wready = ~st_next.w_got & ~st_next.bvalid;

        // Read channel
        if (st_reg.rvalid && I_RREADY) begin
            st_next.rvalid = 1'b0;
        end
        if (I_ARVALID && st_reg.arready) begin
            st_next.rvalid = 1'b1;
            st_next.rresp = addr_ok(I_ARADDR) ? cgm_pkg::CGM_RESP_OKAY : cgm_pkg::CGM_RESP_SLVERR;
            case (I_ARADDR)
                cgm_pkg::CGM_OFS_MODE,
                cgm_pkg::CGM_OFS_BITSET,
                cgm_pkg::CGM_OFS_BITCLR: st_next.rdata = {24'h000000, mode_byte};
                cgm_pkg::CGM_OFS_PROTECT: st_next.rdata = {31'h00000000, st_reg.armed};
                cgm_pkg::CGM_OFS_CTRL: st_next.rdata = {31'h00000000, st_reg.pll_mode};
                cgm_pkg::CGM_OFS_STATUS: st_next.rdata = {28'h0000000, st_reg.fail,
                                                          st_reg.mon_active, I_STAB_COUNTING,
                                                          st_reg.seq == cgm_pkg::CGM_SQ_RUN};
                default: st_next.rdata = 32'h00000000;
            endcase
        end
        st_next.arready = ~st_next.rvalid;

        // Lock hold-off after reset release
        case (st_reg.seq)
            cgm_pkg::CGM_SQ_LOCK: begin
                st_next.lock_cnt = st_reg.lock_cnt + 32'h00000001;
                if (st_reg.lock_cnt >= 32'(LOCK_CYC - 1)) begin
                    st_next.seq = cgm_pkg::CGM_SQ_RUN;
                end
            end
            cgm_pkg::CGM_SQ_RUN: st_next.seq = cgm_pkg::CGM_SQ_RUN;
            default: st_next.seq = cgm_pkg::CGM_SQ_LOCK;
        endcase

        // Clock gating per state
        st_next.gate = '0;
        if (st_reg.seq != cgm_pkg::CGM_SQ_RUN) begin
            st_next.gate.osc = 1'b1;
            st_next.gate.pll = 1'b1;
        end else if (I_STAB_COUNTING) begin
            st_next.gate.osc = 1'b1;
            st_next.gate.pll = 1'b1;
        end else begin
            case (I_PS_STATE)
                cgm_pkg::CGM_PS_NORMAL: st_next.gate = '1;
                cgm_pkg::CGM_PS_HALT: begin
                    st_next.gate = '1;
                    st_next.gate.cpu = 1'b0;
                end
                cgm_pkg::CGM_PS_IDLE: begin
                    st_next.gate.osc = 1'b1;
                    st_next.gate.pll = 1'b1;
                end
                default: st_next.gate = '0;
            endcase
        end

        // System source tick: one per oscillator rising edge, or eight spread over the period
        st_next.per_cnt = st_reg.per_cnt + 16'h0001;
        st_next.phase = st_reg.phase + 16'h0001;
        if (rise) begin
            st_next.per_cnt = 16'h0001;
            st_next.period = st_reg.per_cnt;
            st_next.phase = 16'h0001;
            st_next.ticks_left = st_reg.pll_mode ? 3'h7 : 3'h0;
            st_next.fxx_tick = pll_on;
        end else if (st_reg.pll_mode && st_reg.ticks_left != 3'h0 && st_reg.phase >= step) begin
            st_next.phase = 16'h0001;
            st_next.ticks_left = st_reg.ticks_left - 3'h1;
            st_next.fxx_tick = pll_on;
        end
        // Leaving PLL mode drops ticks still owed, so clock-through never sees a burst
        if (!st_reg.pll_mode) begin
            st_next.ticks_left = 3'h0;
        end

        // Watchdog tick divides the system tick
        if (st_reg.fxx_tick && st_reg.gate.wdt) begin
            st_next.wdt_cnt = st_reg.wdt_cnt + 10'h001;
            if (st_reg.wdt_cnt == cgm_pkg::CGM_WDT_DIV - 10'h001) begin
                st_next.wdt_cnt = 10'h000;
                st_next.wdt_tick = 1'b1;
            end
        end

        // Oscillator monitor, timed by the core clock standing in for the internal oscillator
        st_next.mon_active = st_reg.osc_watch_enable && !I_STAB_COUNTING
                          && st_reg.seq == cgm_pkg::CGM_SQ_RUN && I_PS_STATE != cgm_pkg::CGM_PS_STOP;
        if (!st_reg.mon_active || rise) begin
            st_next.loss_cnt = 16'h0000;
        end else if (st_reg.loss_cnt != 16'hFFFF) begin
            st_next.loss_cnt = st_reg.loss_cnt + 16'h0001;
        end
        if (st_reg.mon_active && st_reg.loss_cnt >= 16'(LOSS_CYC)) begin
            st_next.fail = 1'b1;
        end
        // Active-low fail pin gets its own flop so the pin never glitches through an inverter
        st_next.osc_ok = ~st_next.fail;
    end

    // ======================================================
    // Registers; asynchronous reset also stops every clock
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            st_reg <= '0;
            st_reg.seq <= cgm_pkg::CGM_SQ_LOCK;
            st_reg.osc_ok <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign O_AWREADY = st_reg.awready;
    assign O_WREADY = st_reg.wready;
    assign O_BVALID = st_reg.bvalid;
    assign O_BRESP = st_reg.bresp;
    assign O_ARREADY = st_reg.arready;
    assign O_RVALID = st_reg.rvalid;
    assign O_RDATA = st_reg.rdata;
    assign O_RRESP = st_reg.rresp;
    assign O_GATE = st_reg.gate;
    assign O_FXX_TICK = st_reg.fxx_tick;
    assign O_WDT_TICK = st_reg.wdt_tick;
    assign O_MON_ACTIVE = st_reg.mon_active;
    assign O_OSC_FAIL_N = st_reg.osc_ok;
    assign O_TIMER_HIZ = st_reg.fail;

    // ======================================================
    // Assertions
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_NRST);

    logic wr_fire;
    assign wr_fire = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
    localparam cgm_pkg::cgm_seq_type CGM_SQ_RUN_L = cgm_pkg::CGM_SQ_RUN;

    enable_sticky_a: assert property ($fell(st_reg.osc_watch_enable) |-> 0)
        else $error("monitor enable cleared without reset");
    unlock_needed_a: assert property (wr_fire && !st_reg.armed |=> $stable(st_reg.osc_watch_enable))
        else $error("mode changed without unlock");
    byte_write_a: assert property (wr_fire && st_reg.armed && st_reg.wstrb0 && st_reg.awaddr == 8'h00
        && st_reg.wdata[0] |=> st_reg.osc_watch_enable)
        else $error("unlocked write did not enable monitor");
    stab_inactive_a: assert property (I_STAB_COUNTING |=> !st_reg.mon_active)
        else $error("monitor active during stabilization");
    fail_outputs_a: assert property (st_reg.mon_active && st_reg.loss_cnt >= 16'(LOSS_CYC)
        |=> (!O_OSC_FAIL_N && O_TIMER_HIZ) [*8])
        else $error("oscillator loss not flagged");
    auto_resume_a: assert property (st_reg.osc_watch_enable && $fell(I_STAB_COUNTING)
        && st_reg.seq == CGM_SQ_RUN_L && I_PS_STATE != cgm_pkg::CGM_PS_STOP |=> st_reg.mon_active)
        else $error("monitor did not resume");
    halt_gate_a: assert property (st_reg.seq == CGM_SQ_RUN_L && !I_STAB_COUNTING
        && I_PS_STATE == cgm_pkg::CGM_PS_HALT |=> !O_GATE.cpu && O_GATE.sys && O_GATE.per)
        else $error("halt gating wrong");
    stab_gate_a: assert property (I_STAB_COUNTING |=> O_GATE.pll && !O_GATE.sys && !O_GATE.wdt)
        else $error("stabilization gating wrong");
    lock_hold_a: assert property (st_reg.seq != CGM_SQ_RUN_L |-> !O_GATE.cpu && !O_GATE.sys)
        else $error("clocks released before lock");
    through_one_a: assert property (!st_reg.pll_mode && !rise |=> st_reg.ticks_left == 3'h0)
        else $error("extra ticks in clock-through mode");
    pll_eight_a: assert property (st_reg.pll_mode && rise |=> st_reg.ticks_left == 3'h7)
        else $error("PLL mode did not arm eight ticks");
    bit_set_a: assert property (wr_fire && st_reg.armed && st_reg.wstrb0
        && st_reg.awaddr == cgm_pkg::CGM_OFS_BITSET && st_reg.wdata[2:0] == 3'h0 |=> st_reg.osc_watch_enable)
        else $error("bit set did not enable monitor");
    bit_clear_a: assert property (wr_fire && st_reg.awaddr == cgm_pkg::CGM_OFS_BITCLR
        |=> $stable(st_reg.osc_watch_enable))
        else $error("bit clear changed monitor enable");
    upper_zero_a: assert property (I_ARVALID && st_reg.arready && I_ARADDR == cgm_pkg::CGM_OFS_MODE
        |=> O_RDATA[31:1] == 31'h00000000)
        else $error("mode register upper bits not zero");
    stop_gate_a: assert property (st_reg.seq == CGM_SQ_RUN_L && !I_STAB_COUNTING
        && I_PS_STATE == cgm_pkg::CGM_PS_STOP |=> O_GATE == 6'h00)
        else $error("stop gating wrong");
    tick_gated_a: assert property (!st_reg.gate.pll |=> !O_FXX_TICK)
        else $error("system tick while PLL gated");
    fail_sticky_a: assert property ($fell(O_TIMER_HIZ) |-> 1'b0)
        else $error("timer high impedance released without reset");

    lock_done_c: cover property (st_reg.seq == CGM_SQ_RUN_L);
    wdt_c: cover property (O_WDT_TICK);
    enable_c: cover property ($rose(st_reg.osc_watch_enable));
    fail_c: cover property ($rose(st_reg.fail));
    halt_c: cover property (O_GATE.sys && !O_GATE.cpu);

endmodule
`default_nettype wire

// [cgm_pkg.sv]
package cgm_pkg;

    // ======================================================
    // Register map
    localparam logic [7:0] CGM_OFS_MODE    = 8'h00;
    localparam logic [7:0] CGM_OFS_BITSET  = 8'h04;
    localparam logic [7:0] CGM_OFS_BITCLR  = 8'h08;
    localparam logic [7:0] CGM_OFS_PROTECT = 8'h0C;
    localparam logic [7:0] CGM_OFS_CTRL    = 8'h10;
    localparam logic [7:0] CGM_OFS_STATUS  = 8'h14;
    localparam logic [7:0] CGM_MODE_RST    = 8'h00;
    localparam logic [7:0] CGM_UNLOCK_KEY  = 8'hA5;
    localparam int         CGM_EN_BIT      = 0;
    localparam int         CGM_PLL_BIT     = 0;
    localparam logic [1:0] CGM_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CGM_RESP_SLVERR = 2'h2;

    // ======================================================
    // Timing
    localparam int          CGM_CLK_PERIOD_NS  = 10;
    localparam int          CGM_LOCK_TIME_NS   = 20000;
    localparam int          CGM_LOCK_CYC       = (CGM_LOCK_TIME_NS + CGM_CLK_PERIOD_NS - 1) / CGM_CLK_PERIOD_NS;
    localparam int          CGM_OSC_LOSS_NS    = 1000;
    localparam int          CGM_OSC_LOSS_CYC   = CGM_OSC_LOSS_NS / CGM_CLK_PERIOD_NS;
    localparam logic [3:0]  CGM_PLL_MULT       = 4'h8;
    localparam logic [9:0]  CGM_WDT_DIV        = 10'h200;

    // ======================================================
    // Power-save states and internal sequencing
    typedef enum logic [1:0] {
        CGM_PS_NORMAL = 2'h0,
        CGM_PS_HALT   = 2'h1,
        CGM_PS_IDLE   = 2'h2,
        CGM_PS_STOP   = 2'h3
    } cgm_ps_type;

    typedef enum logic [1:0] {
        CGM_SQ_LOCK = 2'h1,
        CGM_SQ_RUN  = 2'h2
    } cgm_seq_type;

    typedef struct packed {
        logic osc;
        logic pll;
        logic sys;
        logic cpu;
        logic per;
        logic wdt;
    } cgm_gate_type;

endpackage

// [cgm_osc_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Crystal oscillator seen from the clock pin
module cgm_osc_model #(
    parameter int HALF_NS = 80
) (
    input  wire logic i_run,
    output logic      o_osc
);
    // A stopped crystal holds its pin still, so loss shows as no edges
    initial begin
        o_osc = 1'b0;
        #3;
        forever begin
            #(HALF_NS);
            o_osc = i_run ? ~o_osc : 1'b0;
        end
    end
endmodule
`default_nettype wire

// [clock_gen_and_osc_monitor_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module clock_gen_and_osc_monitor_tb;
    localparam int         LOCK         = 8;
    localparam int         LOSS         = 20;
    localparam logic [5:0] GATE_EXP [4] = '{6'h3F, 6'h3B, 6'h30, 6'h00};
    logic                  clk, nrst, awv, wv, bready, arv, rready, osc, osc_run, stab;
    logic                  awr, wr, bv, arr, rv, tick, wdt, mon, fail_n, hiz;
    logic [7:0]            awaddr, araddr;
    logic [31:0]           wdata, rdata, d;
    logic [3:0]            wstrb;
    logic [1:0]            bresp, rresp;
    cgm_pkg::cgm_ps_type   ps;
    cgm_pkg::cgm_gate_type gate;
    int                    bad_count, samples_checked, mode_m, armed, n, k;

    cgm_clock_gen #(.LOCK_CYC(LOCK), .LOSS_CYC(LOSS)) i_cgm_clock_gen (
        .I_CORE_CLK(clk), .I_NRST(nrst), .I_AWADDR(awaddr), .I_AWVALID(awv), .O_AWREADY(awr),
        .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wv), .O_WREADY(wr), .O_BRESP(bresp),
        .O_BVALID(bv), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arv), .O_ARREADY(arr),
        .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rv), .I_RREADY(rready), .I_OSC_CLK(osc),
        .I_PS_STATE(ps), .I_STAB_COUNTING(stab), .O_GATE(gate), .O_FXX_TICK(tick),
        .O_WDT_TICK(wdt), .O_MON_ACTIVE(mon), .O_OSC_FAIL_N(fail_n), .O_TIMER_HIZ(hiz)
    );
    cgm_osc_model i_cgm_osc_model (.i_run(osc_run), .o_osc(osc));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==========================================
    // Checking and closing
    task automatic report_and_stop();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wait_cyc(input int c);
        repeat (c) @(posedge clk);
    endtask

    function automatic logic [1:0] exp_resp(input logic [7:0] a);
        return (a > 8'h14 || a[1:0] != 2'h0) ? cgm_pkg::CGM_RESP_SLVERR : cgm_pkg::CGM_RESP_OKAY;
    endfunction

    // ==========================================
    // Bus master; the model tracks the unlock arm and the sticky enable
    task automatic axi_write(input logic [7:0] a, input logic [7:0] dat);
        logic [31:0] rnd;
        int          w;
        rnd = $urandom();
        @(posedge clk);
        awaddr <= a;
        wdata  <= {rnd[31:8], dat};
        awv    <= 1'b1;
        wv     <= 1'b1;
        bready <= 1'b1;
        w = 0;
        do begin
            @(posedge clk);
            w++;
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
        end while (bv !== 1'b1 && w < 50);
        if (w >= 50) begin
            bad_count++;
            report_and_stop();
        end
        chk(bresp, exp_resp(a));
        bready <= 1'b0;
        if (armed == 1 && a == 8'h00 && dat[0]) mode_m = 1;
        if (armed == 1 && a == 8'h04 && dat[2:0] == 3'h0) mode_m = 1;
        armed = (a == 8'h0C && dat == cgm_pkg::CGM_UNLOCK_KEY) ? 1 : 0;
    endtask

    task automatic axi_read(input logic [7:0] a);
        int w;
        @(posedge clk);
        araddr <= a;
        arv    <= 1'b1;
        rready <= 1'b1;
        w = 0;
        do begin
            @(posedge clk);
            w++;
            if (arv && arr) arv <= 1'b0;
        end while (rv !== 1'b1 && w < 50);
        if (w >= 50) begin
            bad_count++;
            report_and_stop();
        end
        d = rdata;
        chk(rresp, exp_resp(a));
        rready <= 1'b0;
    endtask

    task automatic count_ticks(output int c);
        c = 0;
        repeat (160) begin
            @(posedge clk);
            if (tick === 1'b1) c++;
        end
    endtask

    // ==========================================
    // Main sequence
    initial begin
        nrst = 1'b0;
        {awv, wv, bready, arv, rready, stab} = '0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'hF;
        ps = cgm_pkg::CGM_PS_NORMAL;
        osc_run = 1'b1;
        {bad_count, samples_checked, mode_m, armed} = '0;
        void'($urandom(32'he76cbdbc));
        wait_cyc(4);
        chk(gate, 6'h00);
        chk(fail_n, 1'b1);
        nrst <= 1'b1;
        wait_cyc(3);
        chk(gate, 6'h30);
        wait_cyc(LOCK + 4);
        chk(gate, 6'h3F);
        axi_read(8'h00);
        chk(d, 32'h0000_0000);
        axi_read(8'h20);
        chk(d, 32'h0000_0000);
        axi_write(8'h24, 8'h01);
        axi_write(8'h00, 8'h01);
        axi_read(8'h00);
        chk(d, mode_m);
        axi_write(8'h0C, 8'hA5);
        axi_write(8'h00, 8'hFE);
        axi_read(8'h00);
        chk(d, mode_m);
        axi_write(8'h0C, 8'hA5);
        axi_write(8'h04, 8'h00);
        axi_read(8'h00);
        chk(d, mode_m);
        wait_cyc(LOSS * 2);
        chk(mon, 1'b1);
        chk(fail_n, 1'b1);
        axi_read(8'h14);
        chk(d, 32'h0000_0005);
        axi_write(8'h0C, 8'hA5);
        axi_write(8'h00, 8'h00);
        axi_write(8'h0C, 8'hA5);
        axi_write(8'h08, 8'h00);
        axi_read(8'h00);
        chk(d, 32'h0000_0001);
        for (n = 0; n < 4; n++) begin
            ps <= cgm_pkg::cgm_ps_type'(n);
            wait_cyc(4);
            chk(gate, GATE_EXP[n]);
        end
        ps <= cgm_pkg::CGM_PS_NORMAL;
        stab <= 1'b1;
        wait_cyc(4);
        chk(gate, 6'h30);
        chk(mon, 1'b0);
        stab <= 1'b0;
        wait_cyc(4);
        chk(mon, 1'b1);
        // Ten oscillator periods fit the window; edge phase allows a small slack
        count_ticks(k);
        chk(k >= 8 && k <= 12, 1'b1);
        axi_write(8'h10, 8'h01);
        axi_read(8'h10);
        chk(d, 32'h0000_0001);
        wait_cyc(40);
        count_ticks(k);
        chk(k >= 78 && k <= 82, 1'b1);
        // Watchdog tick: 512 system ticks lie between two of its pulses
        n = 0;
        while (wdt !== 1'b1 && n < 2500) begin
            @(posedge clk);
            n++;
        end
        k = 0;
        do begin
            @(posedge clk);
            n++;
            if (tick === 1'b1) k++;
        end while (wdt !== 1'b1 && n < 5000);
        chk(k, 512);
        osc_run <= 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (fail_n !== 1'b0 && k < 200);
        chk(fail_n, 1'b0);
        wait_cyc(2);
        chk(hiz, 1'b1);
        axi_read(8'h14);
        chk(d, 32'h0000_000D);
        // Reset in mid-run stops every clock and is the only way out of failure and enable
        nrst <= 1'b0;
        osc_run <= 1'b1;
        {mode_m, armed} = '0;
        wait_cyc(2);
        chk(gate, 6'h00);
        chk(fail_n, 1'b1);
        chk(hiz, 1'b0);
        nrst <= 1'b1;
        wait_cyc(3);
        chk(gate, 6'h30);
        axi_read(8'h00);
        chk(d, mode_m);
        report_and_stop();
    end
endmodule
`default_nettype wire
